/* File: fcl_pkg.sv */
package fcl_pkg;
  // field widths of the settings
  localparam int RES_W = 21;  // load edges per motor revolution
  localparam int DIV_W = 15;  // divided output pulses per revolution
  localparam int THR_W = 28;  // deviation threshold
  localparam int DEC_W = 7;   // decay coefficient in percent
  localparam int POS_W = 32;  // position and deviation counters
  localparam int ACC_W = 24;  // divided output phase accumulator
  localparam int CFG_W = 7;   // selection and direction bits

  // register byte offsets on the bus
  localparam logic [7:0] OFF_CFG = 8'h00;       // selection shadow
  localparam logic [7:0] OFF_RES = 8'h04;       // resolution shadow
  localparam logic [7:0] OFF_DIV = 8'h08;       // pulse count shadow
  localparam logic [7:0] OFF_THR = 8'h0C;       // threshold, live
  localparam logic [7:0] OFF_DEC = 8'h10;       // decay coefficient, live
  localparam logic [7:0] OFF_CTRL = 8'h14;      // bit 0 restarts
  localparam logic [7:0] OFF_LOAD_POS = 8'h18;  // load position
  localparam logic [7:0] OFF_DEV = 8'h1C;       // accumulated deviation
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;  // sticky events
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;  // event enables
  localparam logic [7:0] OFF_ACTIVE = 8'h28;    // latched selection

  // bit positions in the selection word
  localparam int CFG_SEL_LSB = 0;   // two bits: encoder selection
  localparam int CFG_SRC_BIT = 2;   // divided output source
  localparam int CFG_PINV_BIT = 3;  // divided output phase invert, load source only
  localparam int CFG_DINV_BIT = 4;  // load count direction invert
  localparam int CFG_ROT_BIT = 5;   // motor rotation direction
  localparam int CFG_IDX_BIT = 6;   // load index setting, stored only
  localparam int CTRL_RESTART_BIT = 0;

  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_ALARM_BIT = 0;  // deviation overflow raised
  localparam int IRQ_REV_BIT = 1;    // motor revolution completed

  // encoder selection codes
  localparam logic [1:0] SEL_NONE = 2'h0;    // semi-closed loop
  localparam logic [1:0] SEL_CLOSED = 2'h1;  // load closes the loop
  localparam logic [1:0] SEL_COUNT = 2'h2;   // load counted only

  // values after reset and limits
  localparam logic [CFG_W-1:0] CFG_DEF = 7'h00;
  localparam logic [RES_W-1:0] RES_DEF = 21'h002710;  // 10000
  localparam logic [RES_W-1:0] RES_MIN = 21'h000001;
  localparam logic [RES_W-1:0] RES_MAX = 21'h100000;  // 1048576
  localparam logic [DIV_W-1:0] DIV_DEF = 15'h4000;    // 16384
  localparam logic [DIV_W-1:0] DIV_MIN = 15'h0010;    // 16
  localparam logic [DIV_W-1:0] DIV_MAX = 15'h4000;    // 16384
  localparam logic [THR_W-1:0] THR_DEF = 28'h00003E8; // 1000
  localparam logic [THR_W-1:0] THR_MAX = 28'h8000000; // 134217728
  localparam logic [DEC_W-1:0] DEC_DEF = 7'h00;
  localparam logic [DEC_W-1:0] DEC_FULL = 7'h64;      // 100 percent
  localparam logic [IRQ_W-1:0] MASK_DEF = 2'h0;
endpackage

/* File: quad_edge_decoder.sv */
module quad_edge_decoder
  import fcl_pkg::*;
(
  // clock and synchronised reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // quadrature pins from outside the clock domain
  input wire logic i_a,
  input wire logic i_b,
  // one pulse per accepted edge, with its direction
  output logic o_step,
  output logic o_up
);
  logic [2:0] sync_r [2];   // three-stage synchroniser per channel
  logic [1:0] stable_r;     // accepted level of a (1) and b (0)
  logic [1:0] stable_nxt;
  logic [1:0] pins;

  assign pins = {i_a, i_b};

  // a change is taken only when stages two and three agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        sync_r[g] <= 3'h0;
      end else begin
        sync_r[g] <= {sync_r[g][1:0], pins[g]};
      end
    end
    assign stable_nxt[g] = (sync_r[g][1] == sync_r[g][2]) ?
                           sync_r[g][2] : stable_r[g];
  end

  // one channel moving is one edge; both moving at once is dropped
  // since its direction cannot be known
  wire [1:0] diff = stable_nxt ^ stable_r;
  wire one_edge = diff[0] ^ diff[1];
  // a leading b counts up: a new a differs from b, or a new b equals a
  wire dir_up = diff[1] ? (stable_nxt[1] != stable_r[0])
                        : (stable_nxt[0] == stable_r[1]);

  // every single-channel edge counts, four per pulse period
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stable_r <= 2'h0;
      o_step <= 1'b0;
      o_up <= 1'b0;
    end else begin
      stable_r <= stable_nxt;
      o_step <= one_edge;   // [R04]
      o_up <= dir_up;       // [R05]
    end
  end
endmodule

/* File: fcl_ext_encoder.sv */
// Function
// R01 - select 1 closes loop, 2 counts only
// R02 - select 0 means no load encoder
// R03 - resolution 1 to 1048576, default 10000
// R04 - every quadrature edge counts, four per period
// R05 - forward counts up, reverse counts down
// R06 - direction setting 0 mapping with invert
// R07 - direction setting 1 mapping with invert
// R08 - forward reference: phase b leads a
// R09 - source 1 uses load, optional phase invert
// R10 - divided count 16 to 16384, default 16384
// R11 - track motor minus load deviation continuously
// R12 - alarm when deviation exceeds live threshold
// R13 - decay coefficient 0 to 100 percent, live
// R14 - coefficient 0 leaves deviation untouched
// R15 - each revolution scales deviation by 1-c/100
// R16 - structure latched at restart, limits live
module fcl_ext_encoder
  import fcl_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // ahb-lite register slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // load encoder pins
  input wire logic i_load_enc_a,
  input wire logic i_load_enc_b,
  // motor encoder feedback, one pulse per load-scaled count
  input wire logic i_motor_step,
  input wire logic i_motor_fwd,
  // divided pulse output and status
  output logic o_div_a,
  output logic o_div_b,
  output logic o_fb_use_load,
  output logic [POS_W-1:0] o_load_pos,
  output logic o_deviation_overflow_alarm,
  output logic o_irq
);
  // reset release through two flip-flops
  logic [1:0] rst_sync_r;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_r[1];

  // address compare used by both decode paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // bus: accepted address phase, then data phase one cycle later
  logic dph_wr_r;              // write data phase pending
  logic [7:0] dph_addr_r;      // its word address
  wire ahb_go = i_hsel & i_htrans[1] & i_hready;
  wire [7:0] a_addr = {i_haddr[7:2], 2'b00};
  wire rd_go = ahb_go & ~i_hwrite;
  wire wr_en = dph_wr_r;
  wire wr_cfg = wr_en & hit(dph_addr_r, OFF_CFG);
  wire wr_res = wr_en & hit(dph_addr_r, OFF_RES);
  wire wr_div = wr_en & hit(dph_addr_r, OFF_DIV);
  wire wr_thr = wr_en & hit(dph_addr_r, OFF_THR);
  wire wr_dec = wr_en & hit(dph_addr_r, OFF_DEC);
  wire wr_mask = wr_en & hit(dph_addr_r, OFF_IRQ_MASK);
  wire restart = wr_en & hit(dph_addr_r, OFF_CTRL)
                 & i_hwdata[CTRL_RESTART_BIT];
  wire rd_stat = rd_go & hit(a_addr, OFF_IRQ_STAT);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      dph_wr_r <= ahb_go & i_hwrite;
      dph_addr_r <= ahb_go ? a_addr : dph_addr_r;
    end
  end

  // software-written settings: shadows and the two live limits
  logic [CFG_W-1:0] cfg_sh_r;
  logic [RES_W-1:0] res_sh_r;
  logic [DIV_W-1:0] div_sh_r;
  logic [THR_W-1:0] thr_r;
  logic [DEC_W-1:0] dec_r;
  logic [IRQ_W-1:0] mask_r;
  // values clamped into range on the way in
  wire [RES_W-1:0] res_in = i_hwdata[RES_W-1:0];
  wire [DIV_W-1:0] div_in = i_hwdata[DIV_W-1:0];
  wire [THR_W-1:0] thr_in = i_hwdata[THR_W-1:0];
  wire [DEC_W-1:0] dec_in = i_hwdata[DEC_W-1:0];
  wire res_big = (|i_hwdata[31:RES_W]) | (res_in > RES_MAX);
  wire [RES_W-1:0] res_ok = res_big ? RES_MAX :
                            (res_in < RES_MIN) ? RES_MIN : res_in; // [R03]
  wire div_big = (|i_hwdata[31:DIV_W]) | (div_in > DIV_MAX);
  wire [DIV_W-1:0] div_ok = div_big ? DIV_MAX :
                            (div_in < DIV_MIN) ? DIV_MIN : div_in; // [R10]
  wire [THR_W-1:0] thr_ok = ((|i_hwdata[31:THR_W]) | (thr_in > THR_MAX))
                            ? THR_MAX : thr_in;                    // [R12]
  wire [DEC_W-1:0] dec_ok = ((|i_hwdata[31:DEC_W]) | (dec_in > DEC_FULL))
                            ? DEC_FULL : dec_in;                   // [R13]

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_sh_r <= CFG_DEF;
      res_sh_r <= RES_DEF;
      div_sh_r <= DIV_DEF;
      thr_r <= THR_DEF;
      dec_r <= DEC_DEF;
      mask_r <= MASK_DEF;
    end else begin
      if (wr_cfg) cfg_sh_r <= i_hwdata[CFG_W-1:0];
      if (wr_res) res_sh_r <= res_ok;
      if (wr_div) div_sh_r <= div_ok;
      if (wr_thr) thr_r <= thr_ok;   // used from the next compare [R16]
      if (wr_dec) dec_r <= dec_ok;   // used at the next revolution [R16]
      if (wr_mask) mask_r <= i_hwdata[IRQ_W-1:0];
    end
  end

  // active structure: copied from the shadows only at restart, so a
  // half-written setup never reaches the counters
  logic [CFG_W-1:0] cfg_r;
  logic [RES_W-1:0] res_r;
  logic [DIV_W-1:0] div_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_DEF;
      res_r <= RES_DEF;
      div_r <= DIV_DEF;
    end else if (restart) begin   // [R16]
      cfg_r <= cfg_sh_r;
      res_r <= res_sh_r;
      div_r <= div_sh_r;
    end
  end
  wire [1:0] sel = cfg_r[CFG_SEL_LSB +: 2];
  wire src_load = cfg_r[CFG_SRC_BIT];
  wire pinv = cfg_r[CFG_PINV_BIT];
  wire dinv = cfg_r[CFG_DINV_BIT];
  wire rot = cfg_r[CFG_ROT_BIT];
  // code 3 is out of range and behaves as no encoder
  wire closed = (sel == SEL_CLOSED);                    // [R01]
  wire cnt_en = closed | (sel == SEL_COUNT);            // [R01] [R02]
  assign o_fb_use_load = closed;                        // [R01] [R02]

  // load encoder edges
  logic q_step;
  logic q_up;
  quad_edge_decoder u_quad (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_a(i_load_enc_a),
    .i_b(i_load_enc_b),
    .o_step(q_step),
    .o_up(q_up)
  );
  wire load_step = q_step & cnt_en;
  // invert flips the count sense of the load encoder
  wire load_up = q_up ^ dinv;                           // [R06] [R07]
  // rotation setting 1 turns a forward reference into reverse movement
  wire load_ref_fwd = load_up ^ rot;                    // [R06] [R07]

  // load position counter
  logic [POS_W-1:0] load_pos_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pos_r <= '0;
    end else if (restart) begin
      load_pos_r <= '0;
    end else if (load_step) begin   // [R05]
      load_pos_r <= load_up ? load_pos_r + 1'b1 : load_pos_r - 1'b1;
    end
  end
  assign o_load_pos = load_pos_r;

  // motor revolution counter, in load edges per revolution
  logic [RES_W-1:0] rev_cnt_r;
  wire rev_up_wrap = i_motor_step & i_motor_fwd & (rev_cnt_r == res_r - 1'b1);
  wire rev_dn_wrap = i_motor_step & ~i_motor_fwd & (rev_cnt_r == '0);
  wire rev_done = rev_up_wrap | rev_dn_wrap;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rev_cnt_r <= '0;
    end else if (restart | rev_up_wrap) begin
      rev_cnt_r <= '0;
    end else if (rev_dn_wrap) begin
      rev_cnt_r <= res_r - 1'b1;
    end else if (i_motor_step) begin
      rev_cnt_r <= i_motor_fwd ? rev_cnt_r + 1'b1 : rev_cnt_r - 1'b1;
    end
  end

  // deviation: motor minus load, both in the reference frame
  function automatic logic signed [POS_W-1:0] decay(
      input logic signed [POS_W-1:0] d, input logic [DEC_W-1:0] c);
    logic signed [POS_W+DEC_W:0] p;
    p = d * $signed({1'b0, DEC_FULL - c});
    return POS_W'(p / $signed({1'b0, DEC_FULL}));
  endfunction
  logic signed [POS_W-1:0] dev_r;
  wire signed [POS_W-1:0] m_d = !i_motor_step ? '0 :
                                 i_motor_fwd ? 32'sh1 : -32'sh1;
  wire signed [POS_W-1:0] l_d = !load_step ? '0 :
                                 load_ref_fwd ? 32'sh1 : -32'sh1;
  wire signed [POS_W-1:0] dev_sum = dev_r + m_d - l_d;    // [R11]
  wire signed [POS_W-1:0] dev_nxt = (rev_done && dec_r != '0)
                                     ? decay(dev_sum, dec_r)    // [R15]
                                     : dev_sum;                 // [R14]
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_r <= '0;
    end else begin
      dev_r <= (restart | ~closed) ? '0 : dev_nxt;              // [R11]
    end
  end
  wire [POS_W-1:0] dev_abs = dev_r[POS_W-1] ? POS_W'(-dev_r)
                                             : POS_W'(dev_r);
  wire over = closed & (dev_abs > {{(POS_W-THR_W){1'b0}}, thr_r});

  // the alarm holds until the next restart
  logic alarm_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= restart ? 1'b0 : (alarm_r | over);             // [R12]
    end
  end
  assign o_deviation_overflow_alarm = alarm_r;

  // sticky events, cleared by a status read; a new event wins
  logic [IRQ_W-1:0] stat_r;
  wire [IRQ_W-1:0] stat_set = {rev_done, over & ~alarm_r};
  wire [IRQ_W-1:0] stat_nxt = (stat_r & {IRQ_W{~rd_stat}}) | stat_set;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end
  assign o_irq = |(stat_r & mask_r);

  // divided output: scale source edges by 4*count/resolution
  logic signed [ACC_W-1:0] acc_r;
  logic [1:0] ph_r;          // two-bit phase count; forward goes 00,01,10,11
  logic div_a_r;
  logic div_b_r;
  wire e_step = src_load ? load_step : i_motor_step;            // [R09]
  wire e_fwd = src_load ? load_ref_fwd : i_motor_fwd;
  wire signed [ACC_W-1:0] inc = $signed(ACC_W'({div_r, 2'b00}));
  wire signed [ACC_W-1:0] res_s = $signed(ACC_W'(res_r));
  wire signed [ACC_W-1:0] acc_in = !e_step ? acc_r :
                                    e_fwd ? acc_r + inc : acc_r - inc;
  // one output edge per clock at most: a very fast source lags behind
  wire out_fwd = acc_in >= res_s;
  wire out_rev = acc_in <= -res_s;
  wire [1:0] ph_nxt = out_fwd ? ph_r + 2'h1 :
                      out_rev ? ph_r - 2'h1 : ph_r;
  wire inv = src_load & pinv;                                   // [R09]
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
      ph_r <= 2'h0;
      div_a_r <= 1'b0;
      div_b_r <= 1'b0;
    end else begin
      acc_r <= restart ? '0 : out_fwd ? acc_in - res_s :
               out_rev ? acc_in + res_s : acc_in;               // [R10]
      ph_r <= restart ? 2'h0 : ph_nxt;
      div_a_r <= ph_nxt[1] ^ inv;                               // [R08]
      div_b_r <= (ph_nxt[1] ^ ph_nxt[0]) ^ inv;                 // [R08]
    end
  end
  assign o_div_a = div_a_r;
  assign o_div_b = div_b_r;

  // read mux and data phase answer; unmapped reads as zero
  wire [31:0] rd_mux =
    hit(a_addr, OFF_CFG) ? 32'(cfg_sh_r) :
    hit(a_addr, OFF_RES) ? 32'(res_sh_r) :
    hit(a_addr, OFF_DIV) ? 32'(div_sh_r) :
    hit(a_addr, OFF_THR) ? 32'(thr_r) :
    hit(a_addr, OFF_DEC) ? 32'(dec_r) :
    hit(a_addr, OFF_LOAD_POS) ? load_pos_r :
    hit(a_addr, OFF_DEV) ? dev_r :
    hit(a_addr, OFF_IRQ_STAT) ? 32'(stat_r) :
    hit(a_addr, OFF_IRQ_MASK) ? 32'(mask_r) :
    hit(a_addr, OFF_ACTIVE) ? 32'(cfg_r) : 32'h0000_0000;
  logic [31:0] hrdata_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata_r <= rd_mux;
    end
  end
  assign o_hrdata = hrdata_r;
  assign o_hreadyout = 1'b1;   // zero wait states
  assign o_hresp = 1'b0;       // always okay

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  property p_sel_none_quiet;
    !cnt_en && !restart |=> $stable(load_pos_r) && dev_r == 0;
  endproperty
  a_sel_none_quiet: assert property (p_sel_none_quiet) // [R02]
    else $error("load counted with no encoder selected");
  property p_count_up;
    load_step && load_up && !restart |=>
      load_pos_r == $past(load_pos_r) + 1;
  endproperty
  a_count_up: assert property (p_count_up) // [R05]
    else $error("load position did not count up");
  property p_count_down;
    load_step && !load_up && !restart |=>
      load_pos_r == $past(load_pos_r) - 1;
  endproperty
  a_count_down: assert property (p_count_down) // [R05]
    else $error("load position did not count down");
  // a load step alone moves the deviation against the reference sense
  property p_ref_map;
    closed && load_step && !i_motor_step && !restart |=>
      dev_r == $past(dev_r) +
               (($past(q_up) ^ $past(dinv) ^ $past(rot)) ? -32'sh1 : 32'sh1);
  endproperty
  a_ref_map: assert property (p_ref_map) // [R06] [R07]
    else $error("reference direction mapping wrong");
  property p_alarm_cause;
    $rose(alarm_r) |-> $past(closed) && $past(dev_abs) > $past(thr_r);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) // [R12]
    else $error("alarm rose without deviation over threshold");
  property p_alarm_raise;
    over && !restart |=> alarm_r;
  endproperty
  a_alarm_raise: assert property (p_alarm_raise) // [R12]
    else $error("deviation over threshold raised no alarm");
  property p_no_decay;
    closed && !restart && !(rev_done && dec_r != 0) |=>
      dev_r == $past(dev_sum);
  endproperty
  a_no_decay: assert property (p_no_decay) // [R14]
    else $error("deviation changed without a decay");
  property p_decay;
    closed && !restart && rev_done && dec_r == DEC_FULL |=> dev_r == 0;
  endproperty
  a_decay: assert property (p_decay) // [R15]
    else $error("full decay left deviation");
  property p_b_leads;
    out_fwd && !restart && !inv |=> (ph_r == 2'h1) |-> o_div_b && !o_div_a;
  endproperty
  a_b_leads: assert property (p_b_leads) // [R08]
    else $error("phase b not leading on forward edge");
  property p_set_wins;
    stat_set[IRQ_REV_BIT] |=> stat_r[IRQ_REV_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) // [R15]
    else $error("revolution event lost");
  property p_latch;
    !restart |=> $stable(cfg_r) && $stable(res_r) && $stable(div_r);
  endproperty
  a_latch: assert property (p_latch) // [R16]
    else $error("structure settings changed without restart");
endmodule

/* File: load_enc_model.sv */
// behavioural quadrature encoder on the machine load
module load_enc_model (
  // sample clock used only to space the edges
  input wire logic i_clk,
  // quadrature channels, always driven
  output logic o_a,
  output logic o_b
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;  // forward order 00, a, ab, b: a leads b counts up
  initial begin
    o_a = 1'b0;
    o_b = 1'b0;
  end
  // one channel edge per step, eight clocks apart so the input filter
  // of the device always sees a settled level between edges
  task move(input int n, input bit fwd);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge i_clk);
      ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
      o_a <= (ph == 1) || (ph == 2);
      o_b <= (ph >= 2);
    end
  endtask
endmodule

/* File: fully_closed_loop_ext_encoder_tb.sv */
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
// self-checking bench: register tasks plus encoder and motor stimulus
module fully_closed_loop_ext_encoder_tb;
  import fcl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;  // 10 MHz system clock
  logic arst_n = 1'b0;  // held low for the first cycles
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic mstep_p = 1'b0;  // motor count pulse
  logic mfwd = 1'b0;  // motor count direction
  logic [31:0] hrdata;
  logic hrdy, hresp, div_a, div_b, fb_load, alarm, irq;
  logic [POS_W-1:0] load_pos;
  logic enc_a, enc_b;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  load_enc_model u_enc (.i_clk(clk), .o_a(enc_a), .o_b(enc_b));
  fcl_ext_encoder u_dut (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_load_enc_a(enc_a),
    .i_load_enc_b(enc_b), .i_motor_step(mstep_p), .i_motor_fwd(mfwd),
    .o_div_a(div_a), .o_div_b(div_b), .o_fb_use_load(fb_load),
    .o_load_pos(load_pos), .o_deviation_overflow_alarm(alarm), .o_irq(irq));
  // verdict in one place, after the counts
  task close_out;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang anywhere ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out;
    end
  end
  // one ahb-lite single transfer; each phase held until hready is seen
  task tx(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    tx(1'b1, a, d, q);
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    tx(1'b0, a, 32'h0, q);
    `CHK(n, e, q)
  endtask
  // structural settings only take hold through a restart
  task restart(input logic [7:0] c);
    wr(OFF_CFG, {24'h0, c});
    wr(OFF_CTRL, 32'h1);
    // let the latched selection settle before anything samples it
    @(posedge clk);
  endtask
  // n consecutive motor counts, then time for the deviation to settle
  task mstep(input int n, input logic f);
    repeat (n) begin
      @(posedge clk);
      mstep_p <= 1'b1;
      mfwd <= f;
    end
    @(posedge clk);
    mstep_p <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // encoder latency is five clocks; twelve leaves margin
  task settle;
    repeat (12) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // defaults, clamping and an unmapped word
    rd("cfg", OFF_CFG, 32'h0);
    rd("res", OFF_RES, 32'h2710);
    rd("div", OFF_DIV, 32'h4000);
    rd("thr", OFF_THR, 32'h3E8);
    rd("dec", OFF_DEC, 32'h0);
    rd("mask", OFF_IRQ_MASK, 32'h0);
    rd("unmapped", 8'h3C, 32'h0);
    `CHK("hresp", 1'b0, hresp)
    wr(OFF_RES, 32'h0);
    rd("res_lo", OFF_RES, 32'h1);
    wr(OFF_DIV, 32'h1);
    rd("div_lo", OFF_DIV, 32'h10);
    wr(OFF_THR, 32'hFFFFFFFF);
    rd("thr_hi", OFF_THR, 32'h8000000);
    wr(OFF_DEC, 32'hC8);
    rd("dec_hi", OFF_DEC, 32'h64);
    $display("test defaults done");
    // no load encoder: movement is not counted
    u_enc.move(4, 1'b1);
    settle;
    `CHK("pos_sel0", 32'h0, load_pos)
    `CHK("fb_sel0", 1'b0, fb_load)
    // closed loop: four edges per period, up then down
    wr(OFF_THR, 32'h3E8);
    wr(OFF_DEC, 32'h0);
    restart(8'h01);
    rd("active", OFF_ACTIVE, 32'h1);
    `CHK("fb_sel1", 1'b1, fb_load)
    u_enc.move(4, 1'b1);
    settle;
    `CHK("pos_up", 32'h4, load_pos)
    rd("dev_rot0", OFF_DEV, 32'hFFFFFFFC);
    u_enc.move(2, 1'b0);
    settle;
    `CHK("pos_down", 32'h2, load_pos)
    restart(8'h21);
    u_enc.move(4, 1'b1);
    settle;
    rd("dev_rot1", OFF_DEV, 32'h4);
    // count only, direction inverted
    restart(8'h12);
    `CHK("fb_sel2", 1'b0, fb_load)
    u_enc.move(4, 1'b1);
    settle;
    `CHK("pos_inv", 32'hFFFFFFFC, load_pos)
    rd("dev_sel2", OFF_DEV, 32'h0);
    $display("test direction done");
    // overflow alarm against a live threshold; a long revolution keeps
    // the revolution event out of the status word
    wr(OFF_RES, 32'h2710);
    restart(8'h01);
    wr(OFF_THR, 32'h3);
    wr(OFF_IRQ_MASK, 32'h3);
    mstep(3, 1'b1);
    `CHK("alarm_eq", 1'b0, alarm)
    `CHK("irq_eq", 1'b0, irq)
    mstep(1, 1'b1);
    `CHK("alarm_over", 1'b1, alarm)
    `CHK("irq_on", 1'b1, irq)
    rd("dev_motor", OFF_DEV, 32'h4);
    rd("stat", OFF_IRQ_STAT, 32'h1);
    rd("stat_clr", OFF_IRQ_STAT, 32'h0);
    `CHK("irq_off", 1'b0, irq)
    $display("test alarm done");
    // decay per revolution, four counts to a revolution
    wr(OFF_RES, 32'h4);
    wr(OFF_THR, 32'h3E8);
    restart(8'h01);
    mstep(4, 1'b1);
    rd("dev_nodecay", OFF_DEV, 32'h4);
    wr(OFF_DEC, 32'h14);
    mstep(4, 1'b1);
    rd("dev_decay", OFF_DEV, 32'h6);
    rd("stat_rev", OFF_IRQ_STAT, 32'h2);
    wr(OFF_DEC, 32'h64);
    mstep(4, 1'b1);
    rd("dev_full", OFF_DEV, 32'h0);
    $display("test decay done");
    // divided output from the load, one output edge per load edge
    wr(OFF_RES, 32'h40);
    wr(OFF_DIV, 32'h10);
    wr(OFF_DEC, 32'h0);
    restart(8'h05);
    u_enc.move(1, 1'b1);
    settle;
    `CHK("div_fwd", 2'b10, {div_b, div_a})
    // rotation 1: reverse load movement is a forward reference
    restart(8'h25);
    u_enc.move(1, 1'b0);
    settle;
    `CHK("div_rot1", 2'b10, {div_b, div_a})
    restart(8'h0D);
    u_enc.move(1, 1'b1);
    settle;
    `CHK("div_inv", 2'b01, {div_b, div_a})
    $display("test divided done");
    close_out;
  end
endmodule
